// file: rtl/pim_channel_mapper_regs.svh
`ifndef PIM_CHANNEL_MAPPER_REGS_SVH
`define PIM_CHANNEL_MAPPER_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define PIM_CFG_OFS       12'h000
`define PIM_STAT_OFS      12'h004
`define PIM_IN_BASE       12'h040
`define PIM_OUT_BASE      12'h080

// ==========================================
// configuration fields
`define PIM_CFG_FULL      0
`define PIM_CFG_BIG       1
`define PIM_CFG_ALIGN     2
`define PIM_CFG_MASK_LO   8
`define PIM_CFG_RST       12'h000

// ==========================================
// status fields
`define PIM_STAT_BYTES_LO 0
`define PIM_STAT_CS_LO    8

`endif

// file: rtl/pim_pkg.sv
package pim_pkg;

    // how the attached coupler treats the control/status byte and bus writes of the configuration
    typedef enum logic [1:0] {
        PIM_CPL_GENERIC,
        PIM_CPL_FORCED_CS,
        PIM_CPL_NO_FB_PARAM,
        PIM_CPL_SPARE
    } pim_coupler_t;

    typedef logic [7:0] pim_byte_t;

endpackage

// file: rtl/pim_channel_mapper.sv
// Register access over APB and the address map are this design's own decisions.
`include "pim_channel_mapper_regs.svh"

module pim_channel_mapper (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  coupler_kind,
    input  wire logic        ser_cfg_wr,
    input  wire logic [11:0] ser_cfg_data,
    input  wire logic [63:0] ch_value,
    input  wire logic [31:0] ch_status,
    output logic      [31:0] ch_control,
    output logic      [4:0]  image_bytes,
    output logic      [3:0]  cs_active
);

    // ==========================================
    // helpers
    function automatic logic [4:0] chan_size(input logic cs, input logic align);
        if (!cs)
            chan_size = 5'h02;
        else if (align)
            chan_size = 5'h04;
        else
            chan_size = 5'h03;
    endfunction

    function automatic logic addr_in(input logic [11:0] a, input logic [11:0] base);
        addr_in = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0);
    endfunction

    // ==========================================
    // state
    logic                [11:0] cfg_q, cfg_d;
    pim_pkg::pim_byte_t         in_img_q  [16];
    pim_pkg::pim_byte_t         in_img_d  [16];
    pim_pkg::pim_byte_t         out_img_q [16];
    pim_pkg::pim_byte_t         out_img_d [16];
    logic                [31:0] ctrl_q, ctrl_d;
    logic                [4:0]  used_q, used_d;
    logic                [3:0]  cs_q;
    logic                [3:0]  cs_on;
    logic                [31:0] prdata_q, prdata_d;
    logic                       pready_q, pready_d;
    logic                       pslverr_q, pslverr_d;
    pim_pkg::pim_coupler_t      kind;
    logic                       commit, fb_locked;
    logic                       hit_cfg, hit_stat, hit_in, hit_out, bad;
    logic                [2:0]  widx;

    assign kind = pim_pkg::pim_coupler_t'(coupler_kind);

    // ==========================================
    // per-channel control/status selection
    always_comb begin
        unique case (kind)
            pim_pkg::PIM_CPL_FORCED_CS: cs_on = 4'hf;
            default: cs_on = cfg_q[`PIM_CFG_FULL] ? cfg_q[`PIM_CFG_MASK_LO +: 4] : 4'h0;
        endcase
    end

    // ==========================================
    // image builder
    always_comb begin
        logic [4:0] pos;
        logic [7:0] first, second;
        pos = 5'h00;
        first = 8'h00;
        second = 8'h00;
        for (int i = 0; i < 16; i++) begin
            in_img_d[i] = 8'h00;
        end
        for (int c = 0; c < 4; c++) begin
            // aligned channels start on a word; an odd pointer only arises after a 3-byte slot
            if (cfg_q[`PIM_CFG_ALIGN] && pos[0]) begin
                pos = pos + 5'h01;
            end
            if (cfg_q[`PIM_CFG_BIG]) begin
                first  = ch_value[16*c+8 +: 8];
                second = ch_value[16*c   +: 8];
            end else begin
                first  = ch_value[16*c   +: 8];
                second = ch_value[16*c+8 +: 8];
            end
            ctrl_d[8*c +: 8] = 8'h00;
            if (cs_on[c]) begin
                in_img_d[pos[3:0]] = ch_status[8*c +: 8];
                ctrl_d[8*c +: 8]   = out_img_q[pos[3:0]];
                if (cfg_q[`PIM_CFG_ALIGN]) begin
                    // byte pos+1 is reserved: left zero, its output copy never read
                    in_img_d[4'(pos + 5'h02)] = first;
                    in_img_d[4'(pos + 5'h03)] = second;
                end else begin
                    in_img_d[4'(pos + 5'h01)] = first;
                    in_img_d[4'(pos + 5'h02)] = second;
                end
            end else begin
                in_img_d[pos[3:0]]        = first;
                in_img_d[4'(pos + 5'h01)] = second;
            end
            pos = pos + chan_size(cs_on[c], cfg_q[`PIM_CFG_ALIGN]);
        end
        used_d = pos;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 16; i++) begin
                in_img_q[i] <= 8'h00;
            end
            ctrl_q <= 32'h0000_0000;
            used_q <= 5'h00;
            cs_q   <= 4'h0;
        end else begin
            in_img_q <= in_img_d;
            ctrl_q   <= ctrl_d;
            used_q   <= used_d;
            cs_q     <= cs_on;
        end
    end

    // ==========================================
    // apb slave: one wait state, answer registered
    always_comb begin
        hit_cfg   = (paddr == `PIM_CFG_OFS);
        hit_stat  = (paddr == `PIM_STAT_OFS);
        hit_in    = addr_in(paddr, `PIM_IN_BASE);
        hit_out   = addr_in(paddr, `PIM_OUT_BASE);
        widx      = paddr[4:2];
        fb_locked = (kind == pim_pkg::PIM_CPL_NO_FB_PARAM);
        bad = !(hit_cfg || hit_stat || hit_in || hit_out)
            || (pwrite && (hit_stat || hit_in))
            || (pwrite && hit_cfg && fb_locked);
        commit    = psel && penable && pready_q;
        pready_d  = psel && penable && !pready_q;
        pslverr_d = pready_d && bad;
        prdata_d  = 32'h0000_0000;
        if (pready_d && !pwrite && !bad) begin
            if (hit_cfg)
                prdata_d = {20'h0_0000, cfg_q};
            else if (hit_stat)
                prdata_d = {20'h0_0000, cs_q, 3'h0, used_q};
            else if (hit_in)
                prdata_d = {16'h0000, in_img_q[{widx, 1'b1}], in_img_q[{widx, 1'b0}]};
            else
                prdata_d = {16'h0000, out_img_q[{widx, 1'b1}], out_img_q[{widx, 1'b0}]};
        end
    end

    // ==========================================
    // configuration and output image
    always_comb begin
        cfg_d     = cfg_q;
        out_img_d = out_img_q;
        // serial path wins over a bus write landing in the same cycle
        if (ser_cfg_wr) begin
            cfg_d = ser_cfg_data;
        end else if (commit && pwrite && hit_cfg && !fb_locked) begin
            cfg_d = pwdata[11:0];
        end
        if (commit && pwrite && hit_out) begin
            out_img_d[{widx, 1'b0}] = pwdata[7:0];
            out_img_d[{widx, 1'b1}] = pwdata[15:8];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_q     <= `PIM_CFG_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                out_img_q[i] <= 8'h00;
            end
        end else begin
            cfg_q     <= cfg_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            out_img_q <= out_img_d;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign ch_control  = ctrl_q;
    assign image_bytes = used_q;
    assign cs_active   = cs_q;

    // ==========================================
    // checks
    default clocking sample_edge @(posedge clock); endclocking
    default disable iff (srst);

    // ==========================================
    // configuration and selection
    AST_RESET_DEFAULT: assert property ($past(srst) && !ser_cfg_wr |-> cfg_q == `PIM_CFG_RST)
        else $error("config not at default after reset");
    AST_SER_WINS: assert property (ser_cfg_wr |=> cfg_q == $past(ser_cfg_data))
        else $error("serial config write lost");
    AST_FB_REFUSED: assert property (commit && pwrite && hit_cfg && fb_locked && !ser_cfg_wr
                                     |=> $stable(cfg_q))
        else $error("bus write changed config on locked coupler");
    AST_FB_ERR: assert property (psel && penable && !pready_q && pwrite && hit_cfg && fb_locked
                                 |=> pready_q && pslverr_q)
        else $error("refused config write not flagged");
    AST_FORCED_CS: assert property (kind == pim_pkg::PIM_CPL_FORCED_CS |=> cs_q == 4'hf)
        else $error("forced coupler without control/status byte");
    AST_GENERIC_OFF: assert property (kind != pim_pkg::PIM_CPL_FORCED_CS && !cfg_q[`PIM_CFG_FULL]
                                      |=> cs_q == 4'h0)
        else $error("control/status byte present with evaluation off");

    // ==========================================
    // layout of the input image
    AST_TWO_BYTES: assert property (cs_on == 4'h0 |=> used_q == 5'h08)
        else $error("no control/status but size is not two bytes per channel");
    AST_CS_LOW_BYTE: assert property (cs_on[0] |=> in_img_q[0] == $past(ch_status[7:0]))
        else $error("status byte not in low byte of first word");
    AST_LE_ORDER: assert property (cs_on == 4'h0 && !cfg_q[`PIM_CFG_BIG]
                                   |=> {in_img_q[1], in_img_q[0]} == $past(ch_value[15:0]))
        else $error("little-endian order wrong");
    AST_BE_ORDER: assert property (cs_on == 4'h0 && cfg_q[`PIM_CFG_BIG]
                                   |=> {in_img_q[0], in_img_q[1]} == $past(ch_value[15:0]))
        else $error("big-endian order wrong");
    AST_ALIGN_RES: assert property (cfg_q[`PIM_CFG_ALIGN] && cs_on[0]
                                    |=> in_img_q[1] == 8'h00)
        else $error("reserved byte not zero");
    AST_ALIGN_DATA: assert property (cfg_q[`PIM_CFG_ALIGN] && cs_on[0] && !cfg_q[`PIM_CFG_BIG]
                                     |=> {in_img_q[3], in_img_q[2]} == $past(ch_value[15:0]))
        else $error("aligned data bytes not in second word");
    AST_ALIGN_BIG: assert property (cfg_q[`PIM_CFG_ALIGN] && cs_on[0] && cfg_q[`PIM_CFG_BIG]
                                    |=> {in_img_q[2], in_img_q[3]} == $past(ch_value[15:0]))
        else $error("aligned big-endian data bytes wrong");
    AST_STATUS_SECOND: assert property (cfg_q[`PIM_CFG_ALIGN] && cs_on[1:0] == 2'h3
                                        |=> in_img_q[4] == $past(ch_status[15:8]))
        else $error("second status byte not on its word boundary");
    AST_ALIGNED_SIZE: assert property (cs_on == 4'hf && cfg_q[`PIM_CFG_ALIGN] |=> used_q == 5'h10)
        else $error("aligned layout size wrong");
    AST_PACKED: assert property (cs_on == 4'hf && !cfg_q[`PIM_CFG_ALIGN] |=> used_q == 5'h0c)
        else $error("packed layout size wrong");
    AST_PACKED_CS1: assert property (cs_on[1:0] == 2'h3 && !cfg_q[`PIM_CFG_ALIGN]
                                     |=> in_img_q[3] == $past(ch_status[15:8]))
        else $error("packed second status byte not at next free byte");
    AST_UNUSED_ZERO: assert property (cs_on == 4'h0 |=> in_img_q[8] == 8'h00 && in_img_q[15] == 8'h00)
        else $error("unused image byte not zero");

    // ==========================================
    // control bytes and output image
    AST_CTRL_TAKE: assert property (cs_on[0] |=> ch_control[7:0] == $past(out_img_q[0]))
        else $error("control byte not taken from output image");
    AST_CTRL_SECOND: assert property (cfg_q[`PIM_CFG_ALIGN] && cs_on[1:0] == 2'h3
                                      |=> ch_control[15:8] == $past(out_img_q[4]))
        else $error("second control byte taken from wrong slot");
    AST_CTRL_NONE: assert property (!cs_on[1] |=> ch_control[15:8] == 8'h00)
        else $error("control byte driven for channel without one");
    AST_OUT_WRITE: assert property (commit && pwrite && hit_out && widx == 3'h0
                                    |=> out_img_q[0] == $past(pwdata[7:0]) && out_img_q[1] == $past(pwdata[15:8]))
        else $error("output image write lost");

    // ==========================================
    // bus answer shape
    AST_READY_PULSE: assert property (pready_q |=> !pready_q)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr_q |-> pready_q)
        else $error("error flag without ready");
    AST_BAD_ERR: assert property (psel && penable && !pready_q && bad
                                  |=> pready_q && pslverr_q)
        else $error("refused access not flagged");
    AST_IDLE_RDATA: assert property (!pready_q |-> prdata_q == 32'h0000_0000)
        else $error("read data not zero outside answer");

    COV_ALIGNED_ALL: cover property (cs_q == 4'hf && cfg_q[`PIM_CFG_ALIGN] && used_q == 5'h10);
    COV_BIG_PACKED: cover property (cfg_q[`PIM_CFG_BIG] && cs_q == 4'hf && used_q == 5'h0c);
    COV_REFUSED: cover property (pready_q && pslverr_q && fb_locked);
    COV_MIXED: cover property (cs_q == 4'h5);
    COV_SERIAL_LOCKED: cover property (ser_cfg_wr && fb_locked);

endmodule // pim_channel_mapper

// file: sim/pim_apb_master.sv
// ==========
// apb master standing in for the coupler
module pim_apb_master (
    input  wire logic        clock,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // no latency assumed: holds the request until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // pim_apb_master

// file: sim/pim_channel_mapper_tb.sv
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module pim_channel_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, err, ser_cfg_wr;
    logic [11:0] paddr, ser_cfg_data, cfg;
    logic [31:0] pwdata, prdata, ch_status, ch_control, rd;
    logic [63:0] ch_value;
    logic [1:0]  coupler_kind;
    logic [4:0]  image_bytes;
    logic [3:0]  cs_active, csmask;
    logic [7:0]  img [16];
    logic [7:0]  oimg [16];
    logic [15:0] d;
    int          cspos [4];
    int          nbytes;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    pim_channel_mapper uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .coupler_kind(coupler_kind), .ser_cfg_wr(ser_cfg_wr), .ser_cfg_data(ser_cfg_data),
        .ch_value(ch_value), .ch_status(ch_status), .ch_control(ch_control),
        .image_bytes(image_bytes), .cs_active(cs_active));
    pim_apb_master bus (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        forever #5 clock = ~clock;
    end
    // about 3700 cycles expected; ceiling well above
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========
    // reference layout
    task automatic model(input logic [11:0] c, input logic [1:0] k);
        int pos;
        logic [15:0] v;
        pos = 0;
        csmask = 4'h0;
        for (int i = 0; i < 16; i++) img[i] = 8'h00;
        for (int ch = 0; ch < 4; ch++) begin
            v = ch_value[16*ch +: 16];
            cspos[ch] = -1;
            if (k == 2'd1 || (c[0] && c[8+ch])) begin
                csmask[ch] = 1'b1;
                cspos[ch] = pos;
                img[pos] = ch_status[8*ch +: 8];
                pos += c[2] ? 2 : 1;
            end
            img[pos] = c[1] ? v[15:8] : v[7:0];
            img[pos+1] = c[1] ? v[7:0] : v[15:8];
            pos += 2;
        end
        nbytes = pos;
    endtask
    task automatic check_image(input logic [11:0] c, input logic [1:0] k);
        logic [7:0] ctl;
        model(c, k);
        for (int w = 0; w < 8; w++) begin
            bus.xfer(1'b0, 12'h040 + 12'(4*w), 32'h0000_0000, rd, err);
            `CHK("input word", {16'h0000, img[2*w+1], img[2*w]}, rd)
            bus.xfer(1'b0, 12'h080 + 12'(4*w), 32'h0000_0000, rd, err);
            `CHK("output word", {16'h0000, oimg[2*w+1], oimg[2*w]}, rd)
        end
        bus.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
        `CHK("cfg", {20'h0_0000, c}, rd)
        bus.xfer(1'b0, 12'h004, 32'h0000_0000, rd, err);
        `CHK("status", {20'h0_0000, csmask, 3'h0, 5'(nbytes)}, rd)
        `CHK("image bytes", 5'(nbytes), image_bytes)
        `CHK("cs active", csmask, cs_active)
        for (int ch = 0; ch < 4; ch++) begin
            ctl = (cspos[ch] < 0) ? 8'h00 : oimg[cspos[ch]];
            `CHK("control", ctl, ch_control[8*ch +: 8])
        end
    endtask
    // ==========
    // main sequence
    initial begin
        coupler_kind = 2'd0;
        ser_cfg_wr = 1'b0;
        ser_cfg_data = 12'h000;
        ch_value = 64'h0000_0000_0000_0000;
        ch_status = 32'h0000_0000;
        for (int i = 0; i < 16; i++) oimg[i] = 8'h00;
        void'($urandom(32'h2f891aac));
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        bus.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
        `CHK("cfg reset", 32'h0000_0000, rd)
        check_image(12'h000, 2'd0);
        for (int i = 0; i < 3; i++) begin
            bus.xfer(1'b1, (i == 0) ? 12'h100 : (i == 1) ? 12'h004 : 12'h040, 32'h0000_00ff, rd, err);
            `CHK("refused write", 1'b1, err)
        end
        $display("test reset and refusals done");
        for (int k = 0; k < 4; k++) begin
            for (int m = 0; m < 8; m++) begin
                @(posedge clock);
                coupler_kind <= 2'(k);
                ch_value <= {$urandom, $urandom};
                ch_status <= $urandom;
                cfg = {4'($urandom), 5'h00, 3'(m)};
                if (k == 2) begin
                    bus.xfer(1'b1, 12'h000, {20'h0_0000, ~cfg}, rd, err);
                    `CHK("fieldbus cfg", 1'b1, err)
                    @(posedge clock);
                    ser_cfg_wr <= 1'b1;
                    ser_cfg_data <= cfg;
                    @(posedge clock);
                    ser_cfg_wr <= 1'b0;
                end else begin
                    bus.xfer(1'b1, 12'h000, {20'h0_0000, cfg}, rd, err);
                end
                for (int w = 0; w < 8; w++) begin
                    d = 16'($urandom);
                    oimg[2*w] = d[7:0];
                    oimg[2*w+1] = d[15:8];
                    bus.xfer(1'b1, 12'h080 + 12'(4*w), {16'h0000, d}, rd, err);
                    `CHK("output write", 1'b0, err)
                end
                check_image(cfg, 2'(k));
                $display("test coupler %0d mode %0d done", k, m);
            end
        end
        // second reset in mid-run: settings and images fall back to defaults
        @(posedge clock);
        srst <= 1'b1;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 16; i++) oimg[i] = 8'h00;
        bus.xfer(1'b0, 12'h000, 32'h0000_0000, rd, err);
        `CHK("cfg reset", 32'h0000_0000, rd)
        check_image(12'h000, coupler_kind);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule // pim_channel_mapper_tb
